/* File: design/adc_cmd_params.svh */
// Purpose: constants for the converter command decoder
// Assumes: 16-bit frames, msb first
// Notes: codes, field positions and reset values
`ifndef ADC_CMD_PARAMS_SVH
`define ADC_CMD_PARAMS_SVH
`define FRAME_BITS 5'h10
`define CMD_BITS 5'h04
`define HALF_BITS 5'h08
`define CMD_PWRDN 4'h8
`define CMD_CFG_RD 4'h9
`define CMD_CFG_WR 4'ha
`define CMD_TEST_MID 4'hb
`define CMD_TEST_LOW 4'hc
`define CMD_TEST_HIGH 4'hd
`define CMD_FIFO_RD 4'he
`define CMD_RESERVED 4'hf
`define CFG_RESET 12'h000
`define CFG_REF_SEL 11
`define CFG_REF_LVL 10
`define CFG_SAMP_LONG 9
`define CFG_CLK_HI 8
`define CFG_CLK_LO 7
`define CFG_MODE_HI 6
`define CFG_MODE_LO 5
`define CFG_SWEEP_HI 4
`define CFG_SWEEP_LO 3
`define CFG_PIN_EOC 2
`define CFG_TRIG_HI 1
`define CFG_TRIG_LO 0
`define SAMP_SHORT 5'h0c
`define SAMP_LONG 5'h18
`define FIFO_TRIG_FULL 4'h7
`define FIFO_TRIG_3Q 4'h5
`define FIFO_TRIG_HALF 4'h3
`define FIFO_TRIG_1Q 4'h1
`endif

/* File: design/adc_cmd_pkg.sv */
// Purpose: types for the converter command decoder
// Assumes: nothing
// Notes: none
package adc_cmd_pkg;
	typedef enum logic [1:0] {mode_single, mode_repeat, mode_sweep,
		mode_repeat_sweep} conv_mode_t;
	typedef enum logic [1:0] {clk_osc, clk_sclk, clk_div4,
		clk_div2} conv_clk_t;
	typedef enum logic [1:0] {src_channel, src_test_mid, src_test_low,
		src_test_high} conv_src_t;
	typedef enum {st_idle, st_shift, st_done} frame_state_t;
endpackage

/* File: design/adc_command_config_decoder.sv */
// Purpose: serial command decoder and configuration register
// Assumes: sclk, cs_n, frame_sync sampled synchronously on ref_clk
// Notes: result and fifo words come from outside via a two-entry buffer
// Behaviour
// - word is 4-bit command plus 12 data
// - most commands act on top nibble alone
// - codes 0-7 pick channels 0-7
// - four-channel: even codes pick channels 0-3
// - code 8 powers down analog and reference
// - code 9 shifts out all 12 configuration bits
// - code a stores 12-bit data to configuration
// - codes b,c,d select mid, low, high tests
// - code e outputs fifo word, low zeros
// - configuration survives power down states
// - halted clock mid write keeps partial state
// - bit 11 selects internal reference
// - bit 10 picks 2 V over 4 V
// - bit 9 picks 24 over 12 clocks
// - bits 8-7 pick conversion clock source
// - bits 6-5 pick mode; single bypasses fifo
// - sweep select honoured only in sweep modes
// - sweep sequences per variant and code
// - bit 2 makes status pin eoc
// - bits 1-0 set fifo trigger level
// - sampling starts after conversion command nibble
// - frame sync or chip select starts cycle
// - conversion reads give previous result first
// - output floats after sixteenth bit
`timescale 1ns/1ps
`include "adc_cmd_params.svh"
module adc_command_config_decoder
	import adc_cmd_pkg::*;
#(
	parameter bit EIGHT_CHANNEL = 1'b1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic frame_sync,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	input wire logic [11:0] word_in,
	input wire logic word_in_valid,
	output logic word_in_ready,
	output logic [11:0] converter_configuration,
	output logic sample_start,
	output logic [5:0] sample_clocks,
	output logic [2:0] channel_sel,
	output conv_src_t conv_source,
	output logic power_down,
	output logic fifo_pop,
	output logic [3:0] fifo_trigger,
	output logic [2:0] sweep_len,
	output logic sweep_enable
);

	typedef struct packed {
		frame_state_t st;
		logic sclk_d;
		logic cs_d;
		logic fs_d;
		logic fs_mode;
		logic [4:0] bitcnt;
		logic [15:0] shin;
		logic [15:0] shout;
		logic so;
		logic so_oe;
		logic [11:0] cfg;
		logic [1:0] bvalid;
		logic [11:0] b0;
		logic [11:0] b1;
		logic [11:0] last_word;
		logic samp;
		logic [5:0] samp_n;
		logic [2:0] chan;
		conv_src_t src;
		logic pdn;
		logic pop;
	} state_t;

	state_t cur_ff, nxt_ff;

	function automatic logic is_conv_cmd(input logic [3:0] c, input bit e8);
		if (c <= 4'h7) begin
			is_conv_cmd = e8 | ~c[0];
		end else begin
			is_conv_cmd = (c == `CMD_TEST_MID) | (c == `CMD_TEST_LOW) |
				(c == `CMD_TEST_HIGH);
		end
	endfunction

	function automatic logic [3:0] trig_level(input logic [1:0] t);
		unique case (t)
			2'b00: trig_level = `FIFO_TRIG_FULL;
			2'b01: trig_level = `FIFO_TRIG_3Q;
			2'b10: trig_level = `FIFO_TRIG_HALF;
			2'b11: trig_level = `FIFO_TRIG_1Q;
		endcase
	endfunction

	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic fs_fall;
	logic start;
	logic shift_edge;
	logic out_edge;
	logic [3:0] cmd;
	logic [15:0] word_now;
	logic single;
	logic [3:0] slen_full;

	// delayed copies reset to the idle pin levels, so no false edge
	assign sclk_rise = sclk & ~cur_ff.sclk_d;
	assign sclk_fall = ~sclk & cur_ff.sclk_d;
	assign cs_fall = ~cs_n & cur_ff.cs_d;
	assign fs_fall = ~frame_sync & cur_ff.fs_d & ~cs_n;

	// dsp framing samples on falling clock edges, spi on rising
	assign shift_edge = cur_ff.fs_mode ? sclk_fall : sclk_rise;
	assign out_edge = cur_ff.fs_mode ? sclk_rise : sclk_fall;

	assign word_now = {cur_ff.shin[14:0], serial_in};

	// at the fourth edge the nibble sits in the low bits of the shifter
	assign cmd = word_now[3:0];

	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.sclk_d = sclk;
		nxt_ff.cs_d = cs_n;
		nxt_ff.fs_d = frame_sync;
		nxt_ff.samp = 1'b0;
		nxt_ff.pop = 1'b0;
		start = 1'b0;

		// buffer fill: holds word until a read frame takes it
		if (word_in_valid && cur_ff.bvalid != 2'b11) begin
			if (cur_ff.bvalid[0]) begin
				nxt_ff.b1 = word_in;
				nxt_ff.bvalid[1] = 1'b1;
			end else begin
				nxt_ff.b0 = word_in;
				nxt_ff.bvalid[0] = 1'b1;
			end
		end

		// frame start
		if (cs_n) begin
			nxt_ff.st = st_idle;
			nxt_ff.so_oe = 1'b0;
		end else if (cs_fall) begin
			// frame sync high at chip select fall means spi framing
			nxt_ff.fs_mode = ~frame_sync;
			start = frame_sync;
		end else if (fs_fall) begin
			start = 1'b1;
		end

		if (start) begin
			nxt_ff.st = st_shift;
			nxt_ff.bitcnt = 5'h00;
			// previous result leads the word, don't-care tail is zero
			nxt_ff.shout = {cur_ff.last_word, 4'h0};
			nxt_ff.so = cur_ff.last_word[11];
			nxt_ff.so_oe = 1'b1;
		end

		// shifting
		if (cur_ff.st == st_shift && !cs_n) begin

			// no edge means no progress, so a paused write simply waits
			if (shift_edge) begin
				nxt_ff.shin = word_now;
				nxt_ff.bitcnt = cur_ff.bitcnt + 5'h01;

				if (cur_ff.bitcnt == `CMD_BITS - 5'h01) begin
					// act on nibble alone; data field ignored here
					if (is_conv_cmd(cmd, EIGHT_CHANNEL)) begin
						nxt_ff.samp = 1'b1;
						nxt_ff.pdn = 1'b0;

						if (cmd[3] == 1'b0) begin
							nxt_ff.src = src_channel;
							nxt_ff.chan = EIGHT_CHANNEL ? cmd[2:0] :
								{1'b0, cmd[2:1]};
						end else if (cmd == `CMD_TEST_MID) begin
							nxt_ff.src = src_test_mid;
						end else if (cmd == `CMD_TEST_LOW) begin
							nxt_ff.src = src_test_low;
						end else begin
							nxt_ff.src = src_test_high;
						end

						if (cur_ff.bvalid[0]) begin
							nxt_ff.last_word = cur_ff.b0;
							nxt_ff.pop = 1'b1;
						end

					end else if (cmd == `CMD_PWRDN) begin
						nxt_ff.pdn = 1'b1;

					end else if (cmd == `CMD_CFG_RD) begin
						// three bits already left; register fills the
						// twelve output slots still to come
						nxt_ff.shout[14:3] = cur_ff.cfg;

					end else if (cmd == `CMD_FIFO_RD) begin
						nxt_ff.shout[3:0] = 4'h0;
						if (cur_ff.bvalid[0]) begin
							nxt_ff.last_word = cur_ff.b0;
							nxt_ff.pop = 1'b1;
						end
					end
					// reserved code falls through untouched
				end

				if (cur_ff.bitcnt == `FRAME_BITS - 5'h01) begin
					nxt_ff.st = st_done;
					if (word_now[15:12] == `CMD_CFG_WR) begin
						nxt_ff.cfg = word_now[11:0];
					end
				end
			end

			if (out_edge && cur_ff.bitcnt != 5'h00) begin
				nxt_ff.shout = {cur_ff.shout[14:0], 1'b0};
				nxt_ff.so = cur_ff.shout[14];
				if (cur_ff.bitcnt == `FRAME_BITS) begin
					nxt_ff.so_oe = 1'b0;
				end
			end

		end else if (cur_ff.st == st_done && out_edge) begin
			nxt_ff.so_oe = 1'b0;
		end

		// popped word leaves the buffer; shift second entry down
		if (nxt_ff.pop) begin
			nxt_ff.b0 = nxt_ff.bvalid[1] ? nxt_ff.b1 : nxt_ff.b0;
			nxt_ff.bvalid = {1'b0, nxt_ff.bvalid[1]};
		end

		nxt_ff.samp_n = cur_ff.cfg[`CFG_SAMP_LONG] ? 6'(`SAMP_LONG) :
			6'(`SAMP_SHORT);
	end

	// power down never touches cfg, so settings survive it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_ff <= '0;
			cur_ff.sclk_d <= 1'b0;
			cur_ff.cs_d <= 1'b1;
			cur_ff.fs_d <= 1'b1;
			cur_ff.cfg <= `CFG_RESET;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign single = cur_ff.cfg[`CFG_MODE_HI:`CFG_MODE_LO] == 2'b00;

	// trigger level doubles as the sweep length
	assign slen_full = trig_level(cur_ff.cfg[`CFG_TRIG_HI:`CFG_TRIG_LO]);


	always_comb begin
		serial_out = cur_ff.so;
		serial_out_oe = cur_ff.so_oe;
		word_in_ready = ~cur_ff.bvalid[1];
		// bits 11..2 decoded downstream by analog and timing logic
		converter_configuration = cur_ff.cfg;
		sample_start = cur_ff.samp;
		sample_clocks = cur_ff.samp_n;
		channel_sel = cur_ff.chan;
		conv_source = cur_ff.src;
		power_down = cur_ff.pdn;
		fifo_pop = cur_ff.pop;
	end

	// mode-dependent outputs are registered below to stay flop-driven
	logic [3:0] trig_ff;
	logic [2:0] slen_ff;
	logic sweep_ff;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_ff <= 4'h0;
			slen_ff <= 3'h0;
			sweep_ff <= 1'b0;
		end else begin
			// single shot bypasses fifo; trigger forced off
			trig_ff <= single ? 4'h0 : slen_full;

			slen_ff <= slen_full[2:0];

			sweep_ff <= cur_ff.cfg[`CFG_MODE_HI] &&
				(EIGHT_CHANNEL || cur_ff.cfg[4:3] != 2'b00);
		end
	end
	assign fifo_trigger = trig_ff;
	assign sweep_len = slen_ff;
	assign sweep_enable = sweep_ff;

endmodule

/* File: testbench/decoder_props.sv */
// Purpose: port checks for the command decoder
// Assumes: spi style frames, frame_sync high
// Notes: bound from tb_top
`timescale 1ns/1ps
module decoder_props (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic frame_sync,
	input wire logic serial_out_oe,
	input wire logic sample_start,
	input wire logic [5:0] sample_clocks,
	input wire logic [11:0] converter_configuration,
	input wire logic [3:0] fifo_trigger,
	input wire logic power_down,
	input wire logic sweep_enable
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_oe_release: assert property (
		$rose(cs_n) |-> ##[0:4] !serial_out_oe) else $error("oe stuck");
	a_oe_start: assert property (
		$fell(cs_n) && frame_sync |-> ##[1:6] serial_out_oe)
		else $error("oe late");
	a_start_pulse: assert property (
		sample_start |=> !sample_start) else $error("start too long");
	a_samp_len: assert property (
		sample_start |-> sample_clocks ==
		(converter_configuration[9] ? 6'h18 : 6'h0c))
		else $error("sample length");
	a_trig_level: assert property (
		$stable(converter_configuration) |-> fifo_trigger ==
		(converter_configuration[6:5] == 2'h0 ? 4'h0 :
		4'h7 - {1'b0, converter_configuration[1:0], 1'b0}))
		else $error("trigger level");
	a_sweep_off: assert property (
		$stable(converter_configuration) && !converter_configuration[6]
		|-> !sweep_enable) else $error("sweep on");
	a_cfg_frame: assert property (
		!$stable(converter_configuration) |-> !cs_n)
		else $error("config outside frame");
	a_pd_keep: assert property (
		$rose(power_down) |-> $stable(converter_configuration))
		else $error("config lost");
endmodule

/* File: testbench/host_port_model.sv */
// Purpose: host serial port issuing 16-bit frames
// Assumes: sclk phase of four ref_clk cycles
// Notes: sclk idles low, serial_in flips after a frame
`timescale 1ns/1ps
module host_port_model (
	input wire logic ref_clk,
	output logic sclk,
	output logic cs_n,
	output logic serial_in,
	input wire logic serial_out
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		serial_in = 1'b0;
	end
	// halt holds sclk high after eight bits, like a stalled port
	task automatic frame(input logic [15:0] w, input bit halt,
		output logic [15:0] rx);
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serial_in = w[i];
			repeat (4) @(posedge ref_clk);
			#1 sclk = 1'b1;
			rx[i] = serial_out;
			repeat (4) @(posedge ref_clk);
			if (halt && i == 8)
				repeat (40) @(posedge ref_clk);
			#1 sclk = 1'b0;
		end
		repeat (4) @(posedge ref_clk);
		#1 cs_n = 1'b1;
		serial_in = ~serial_in;
		repeat (4) @(posedge ref_clk);
		#1;
	endtask
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the command decoder
// Assumes: eight channel build, spi frames
// Notes: words fed to the buffer are queued in order
`timescale 1ns/1ps
module tb_top;
	import adc_cmd_pkg::*;
	logic ref_clk = 1'b0, rst_n = 1'b0, frame_sync = 1'b1;
	logic sclk, cs_n, serial_in, serial_out, serial_out_oe;
	logic [11:0] word_in = 12'h000, converter_configuration, cfg;
	logic word_in_valid = 1'b0, word_in_ready, sample_start;
	logic power_down, fifo_pop, sweep_enable;
	logic [5:0] sample_clocks;
	logic [3:0] fifo_trigger;
	logic [2:0] channel_sel, sweep_len;
	conv_src_t conv_source;
	logic [15:0] rx;
	logic [11:0] last_w = 12'h000;
	logic [4:0] exp_q[$];
	logic [11:0] word_q[$];
	int error_cnt = 0, tests_run = 0, seed = 32'hc59fa446, n;
	always #5 ref_clk = ~ref_clk;
	adc_command_config_decoder adc_command_config_decoder_inst(.*);
	host_port_model host_port_model_inst(.ref_clk, .sclk, .cs_n,
		.serial_in, .serial_out);
	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task xfer(input logic [15:0] w, input bit halt = 1'b0);
		host_port_model_inst.frame(w, halt, rx);
	endtask
	task conv(input logic [3:0] code, input logic [4:0] sel);
		exp_q.push_back(sel);
		xfer({code, 12'h000});
		check(rx, {last_w, 4'h0});
		last_w = word_q.pop_front();
		check(exp_q.size(), 0);
	endtask
	always @(negedge ref_clk) begin
		if (sample_start) begin
			if (exp_q.size() == 0)
				check(16'h1, 16'h0);
			else
				check({conv_source, conv_source == src_channel ?
					channel_sel : 3'h0}, exp_q.pop_front());
		end
		if (word_in_valid && word_in_ready) begin
			word_q.push_back(word_in);
			word_in <= #6 12'($random(seed));
		end
	end
	initial begin
		#1000000 check(16'h0, 16'h1);
		wrap_up();
	end
	initial begin
		repeat (5) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		xfer(16'h9000);
		check(rx[11:0], 12'h000);
		word_in_valid = 1'b1;
		n = 0;
		while (word_in_ready === 1'b1 && n < 20) begin
			@(posedge ref_clk);
			#1 n++;
		end
		check(word_q.size(), 2);
		// long sampling kept set: sclk here is above 10 MHz
		cfg = (12'($random(seed)) & 12'hf9f) | 12'h200;
		xfer({4'ha, cfg}, 1'b1);
		check(converter_configuration, cfg);
		xfer(16'h9000);
		check(rx[11:0], cfg);
		xfer({4'hf, ~cfg});
		check(converter_configuration, cfg);
		for (int c = 0; c < 8; c++)
			conv(4'(c), 5'(c));
		for (int c = 1; c < 4; c++)
			conv(4'(c + 10), {2'(c), 3'h0});
		xfer(16'he000);
		check(rx, {last_w, 4'h0});
		last_w = word_q.pop_front();
		for (int t = 0; t < 4; t++) begin
			xfer({4'ha, cfg[11:7], 2'h2, cfg[4:2], 2'(t)});
			check(fifo_trigger, 4'h7 - 4'(2 * t));
			check(sweep_len, 3'h7 - 3'(2 * t));
			check(sweep_enable, 1'b1);
		end
		xfer({4'ha, cfg});
		xfer(16'h8000);
		check(power_down, 1'b1);
		xfer(16'h9000);
		check(rx[11:0], cfg);
		$display("scenarios done");
		wrap_up();
	end
endmodule
bind adc_command_config_decoder decoder_props decoder_props_inst(.*);
